//--- core/iepf_irq_regs.sv
// Interrupt enable, priority and flag register set with request selection
`timescale 1ns/100ps
// Contract
// RL1 - Primary enable register, global gate top
// RL2 - Extended enable register for eight sources
// RL3 - Each source has own priority bit
// RL4 - Priority one means high level
// RL5 - Primary priority layout, bit 7 unused
// RL6 - Extended priority mirrors extended enable
// RL7 - Line flags read-only, writes ignored
// RL8 - I2C master flag sticky until software clears
// RL9 - Timer and watchdog flags live outside
// RL10 - Line flags follow peripheral, not latched
// RL11 - Line flag is OR of causes
// RL12 - Software clears cause inside peripheral
// RL13 - Remaining cause keeps request asserted
// RL14 - Request only when enabled
// RL15 - High before low, then natural order
// RL16 - Requests sampled each rising clock
// RL17 - Global gate zero blocks all dispatch
module iepf_irq_regs
  import iepf_pkg::*;
#(
  parameter int unsigned CAUSES = CAUSE_W
) (
  input  wire logic                 core_clk_in,
  input  wire logic                 rst_in,
  input  wire logic [ADDR_W-1:0]    addr_in,
  input  wire logic [DATA_W-1:0]    wdata_in,
  input  wire logic                 wr_in,
  input  wire logic                 rd_in,
  output logic      [DATA_W-1:0]    rdata_out,
  input  wire logic                 pin_group0_req_in,
  input  wire logic                 pin_group1_req_in,
  input  wire logic                 timer0_flag_in,
  input  wire logic                 timer1_flag_in,
  input  wire logic                 timer2_flag_in,
  input  wire logic                 uart0_req_in,
  input  wire logic                 uart2_req_in,
  input  wire logic                 watchdog_flag_in,
  input  wire logic                 i2c_master_event_in,
  input  wire logic [6*CAUSES-1:0]  line_cause_in,
  output logic                      irq_req_out,
  output logic      [SRC_W-1:0]     irq_src_out,
  output logic                      irq_high_out,
  output logic                      irq_out
);
  // Positions of the six peripheral lines in the live OR vector
  localparam int unsigned NUM_LINES     = 6;
  localparam int unsigned LOW_VOLT_LINE = 0;
  localparam int unsigned COMP_LINE     = 1;
  localparam int unsigned CONV_LINE     = 2;
  localparam int unsigned COUNTER_LINE  = 3;
  localparam int unsigned SPI_LINE      = 4;
  localparam int unsigned RTC_LINE      = 5;
  // Primary registers carry seven sources below the gate bit
  localparam int unsigned PRI_SRC_W     = 7;

  logic [7:0] primary_irq_enable_reg;
  logic [7:0] primary_irq_priority_reg;
  logic [7:0] extended_irq_enable_reg;
  logic [7:0] extended_irq_priority_reg;
  logic       i2c_master_pending_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_mask_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic       irq_req_reg;
  logic [SRC_W-1:0] irq_src_reg;
  logic       irq_high_reg;
  logic       irq_reg;
  logic [NUM_SRC-1:0] raw_sampled_reg;

  logic [NUM_LINES-1:0] line_flags;
  logic       rtc_timer3_line_flag;
  logic       spi_slave_cec_line_flag;
  logic       counter_array_line_flag;
  logic       converter_pwm_line_flag;
  logic       comparator_can_line_flag;
  logic       low_voltage_line_flag;
  logic [7:0] external_irq_flags;
  logic [NUM_SRC-1:0] raw_req;
  logic [NUM_SRC-1:0] enable_vec;
  logic [NUM_SRC-1:0] level_vec;
  logic [NUM_SRC-1:0] gated_req;
  logic       arb_valid;
  logic [SRC_W-1:0] arb_src;
  logic       wr_ext_flags;
  logic [7:0] status_set;
  logic [7:0] status_next;
  logic       wr_pri_enable;
  logic       wr_pri_priority;
  logic       wr_ext_enable;
  logic       wr_ext_priority;
  logic       wr_status;
  logic       wr_mask;

  // Strobe and address meet here once for every register
  function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
    return wr && (a == target);
  endfunction

  // Level of the winner; an index past the last source reads low, never unknown
  function automatic logic level_at(input logic [NUM_SRC-1:0] lv, input logic [SRC_W-1:0] idx);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (idx == SRC_W'(i)) begin
        hit = lv[i];
      end
    end
    return hit;
  endfunction

  // RL10 live line flags
  iepf_line_or #(
    .LINES  (NUM_LINES),
    .CAUSES (CAUSES)
  ) u_line_or (
    .cause_in (line_cause_in),
    .line_out (line_flags)
  );

  assign low_voltage_line_flag    = line_flags[LOW_VOLT_LINE];
  assign comparator_can_line_flag = line_flags[COMP_LINE];
  assign converter_pwm_line_flag  = line_flags[CONV_LINE];
  assign counter_array_line_flag  = line_flags[COUNTER_LINE];
  assign spi_slave_cec_line_flag  = line_flags[SPI_LINE];
  assign rtc_timer3_line_flag     = line_flags[RTC_LINE];

  // RL7 flag register view, bit 4 reads zero
  assign external_irq_flags = {rtc_timer3_line_flag, spi_slave_cec_line_flag, counter_array_line_flag, 1'b0,
                               converter_pwm_line_flag, comparator_can_line_flag, low_voltage_line_flag,
                               i2c_master_pending_reg};

  // Register write decode; writes to unmapped addresses fall away here
  assign wr_ext_flags    = wr_hit(wr_in, addr_in, ADDR_EXT_FLAGS);
  assign wr_pri_enable   = wr_hit(wr_in, addr_in, ADDR_PRI_ENABLE);
  assign wr_pri_priority = wr_hit(wr_in, addr_in, ADDR_PRI_PRIORITY);
  assign wr_ext_enable   = wr_hit(wr_in, addr_in, ADDR_EXT_ENABLE);
  assign wr_ext_priority = wr_hit(wr_in, addr_in, ADDR_EXT_PRIORITY);
  assign wr_status       = wr_hit(wr_in, addr_in, ADDR_IRQ_STATUS);
  assign wr_mask         = wr_hit(wr_in, addr_in, ADDR_IRQ_MASK);

  // RL1 primary enable, global gate in bit 7
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      primary_irq_enable_reg <= RESET_VALUE;
    end else if (wr_pri_enable) begin
      primary_irq_enable_reg <= wdata_in;
    end
  end

  // RL2 extended enable
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      extended_irq_enable_reg <= RESET_VALUE;
    end else if (wr_ext_enable) begin
      extended_irq_enable_reg <= wdata_in;
    end
  end

  // RL5 primary priority, bit 7 kept zero
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      primary_irq_priority_reg <= RESET_VALUE;
    end else if (wr_pri_priority) begin
      primary_irq_priority_reg <= wdata_in & PRI_PRIORITY_MASK;
    end
  end

  // RL6 extended priority
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      extended_irq_priority_reg <= RESET_VALUE;
    end else if (wr_ext_priority) begin
      extended_irq_priority_reg <= wdata_in;
    end
  end

  // Only bit 0 of the flag register is writable; the line bits are views
  // RL8 sticky master flag; a new event beats a software clear
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      i2c_master_pending_reg <= 1'b0;
    end else if (i2c_master_event_in) begin
      i2c_master_pending_reg <= 1'b1;
    end else if (wr_ext_flags) begin
      i2c_master_pending_reg <= wdata_in[I2C_MASTER_BIT];
    end
  end

  // Source vector in natural order, index 0 serviced first among equals
  // RL9 timer and watchdog flags come straight from their peripherals
  always_comb begin
    raw_req = {rtc_timer3_line_flag, spi_slave_cec_line_flag, counter_array_line_flag, watchdog_flag_in,
               converter_pwm_line_flag, comparator_can_line_flag, low_voltage_line_flag,
               i2c_master_pending_reg, uart2_req_in, timer2_flag_in, uart0_req_in, timer1_flag_in,
               pin_group1_req_in, timer0_flag_in, pin_group0_req_in};
    enable_vec = {extended_irq_enable_reg, primary_irq_enable_reg[PRI_SRC_W-1:0]};
    // RL3 one level bit per source
    level_vec  = {extended_irq_priority_reg, primary_irq_priority_reg[PRI_SRC_W-1:0]};
  end

  // One flop of latency buys a settled arbiter input
  // RL16 requests sampled each rising edge
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      raw_sampled_reg <= '0;
    end else begin
      raw_sampled_reg <= raw_req;
    end
  end

  // RL14 enable gating
  // RL17 global gate blocks every source request
  // RL13 uncleared cause keeps requesting
  assign gated_req = primary_irq_enable_reg[GLOBAL_GATE_BIT] ? (raw_sampled_reg & enable_vec) : '0;

  iepf_arbiter #(
    .N (NUM_SRC)
  ) u_arbiter (
    .req_in    (gated_req),
    .high_in   (level_vec),
    .valid_out (arb_valid),
    .src_out   (arb_src)
  );

  // Outputs leave from flops; the arbiter itself is combinational
  // RL4 level one reports high
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_req_reg  <= 1'b0;
      irq_src_reg  <= NO_SOURCE;
      irq_high_reg <= 1'b0;
    end else begin
      irq_req_reg  <= arb_valid;
      irq_src_reg  <= arb_src;
      irq_high_reg <= arb_valid && level_at(level_vec, arb_src);
    end
  end

  // Event status: dispatch start and master flag set; set wins over clear
  assign status_set = {6'h00, i2c_master_event_in, arb_valid && !irq_req_reg};

  // Clear and set land in one step so a same-cycle event is never lost
  always_comb begin
    status_next = irq_status_reg;
    if (wr_status) begin
      status_next = irq_status_reg & ~wdata_in;
    end
    status_next = (status_next | status_set) & STATUS_MASK;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status_reg <= RESET_VALUE;
    end else begin
      irq_status_reg <= status_next;
    end
  end

  // Mask bits beyond the two events stay zero
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_mask_reg <= RESET_VALUE;
    end else if (wr_mask) begin
      irq_mask_reg <= wdata_in & STATUS_MASK;
    end
  end

  // Uses next status so the line drops the cycle after a clear
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_next & irq_mask_reg);
    end
  end

  // Read port, data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= RESET_VALUE;
    end else if (rd_in) begin
      case (addr_in)
        ADDR_EXT_FLAGS:    rdata_reg <= external_irq_flags;
        ADDR_PRI_ENABLE:   rdata_reg <= primary_irq_enable_reg;
        ADDR_PRI_PRIORITY: rdata_reg <= primary_irq_priority_reg;
        ADDR_EXT_ENABLE:   rdata_reg <= extended_irq_enable_reg;
        ADDR_EXT_PRIORITY: rdata_reg <= extended_irq_priority_reg;
        ADDR_IRQ_STATUS:   rdata_reg <= irq_status_reg;
        ADDR_IRQ_MASK:     rdata_reg <= irq_mask_reg;
        default:           rdata_reg <= RESET_VALUE;
      endcase
    end else begin
      rdata_reg <= RESET_VALUE;
    end
  end

  assign rdata_out    = rdata_reg;
  assign irq_req_out  = irq_req_reg;
  assign irq_src_out  = irq_src_reg;
  assign irq_high_out = irq_high_reg;
  assign irq_out      = irq_reg;
endmodule

//--- core/iepf_pkg.sv
// Package: register map, bit positions and source numbering of the interrupt register set
package iepf_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_SRC = 15;
  localparam int unsigned SRC_W = 4;
  localparam logic [7:0] ADDR_EXT_FLAGS    = 8'h91;
  localparam logic [7:0] ADDR_PRI_ENABLE   = 8'ha8;
  localparam logic [7:0] ADDR_PRI_PRIORITY = 8'hb8;
  localparam logic [7:0] ADDR_EXT_ENABLE   = 8'he8;
  localparam logic [7:0] ADDR_EXT_PRIORITY = 8'hf8;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'hc0;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'hc1;
  localparam logic [7:0] RESET_VALUE       = 8'h00;
  localparam logic [7:0] PRI_PRIORITY_MASK = 8'h7f;
  localparam logic [7:0] EXT_FLAGS_RO_MASK = 8'hee;
  localparam logic [7:0] STATUS_MASK       = 8'h03;
  localparam int unsigned GLOBAL_GATE_BIT  = 7;
  localparam int unsigned I2C_MASTER_BIT   = 0;
  localparam int unsigned EV_DISPATCH_BIT  = 0;
  localparam int unsigned EV_I2C_SET_BIT   = 1;
  localparam logic [3:0] NO_SOURCE         = 4'hf;
  // Number of cause inputs per external peripheral line
  localparam int unsigned CAUSE_W = 4;
endpackage

//--- core/iepf_line_or.sv
// Line flag: live OR of a peripheral's cause flags
`timescale 1ns/100ps
module iepf_line_or
  import iepf_pkg::*;
#(
  parameter int unsigned LINES = 6,
  parameter int unsigned CAUSES = CAUSE_W
) (
  input  wire logic [LINES*CAUSES-1:0] cause_in,
  output logic      [LINES-1:0]        line_out
);
  always_comb begin
    for (int i = 0; i < LINES; i++) begin
      // RL11 any cause sets
      line_out[i] = |cause_in[i*CAUSES +: CAUSES];
    end
  end
endmodule

//--- core/iepf_arbiter.sv
// Two-level fixed-order arbiter over the request vector
`timescale 1ns/100ps
module iepf_arbiter
  import iepf_pkg::*;
#(
  parameter int unsigned N = NUM_SRC
) (
  input  wire logic [N-1:0] req_in,
  input  wire logic [N-1:0] high_in,
  output logic              valid_out,
  output logic [SRC_W-1:0]  src_out
);
  function automatic logic [SRC_W:0] pick(input logic [N-1:0] v);
    logic [SRC_W:0] r;
    r = {1'b0, NO_SOURCE};
    // Lowest index wins so scan downward
    for (int i = N - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, SRC_W'(i)};
      end
    end
    return r;
  endfunction

  logic [SRC_W:0] hi_pick;
  logic [SRC_W:0] lo_pick;
  always_comb begin
    hi_pick = pick(req_in & high_in);
    lo_pick = pick(req_in & ~high_in);
    // RL15 high before low
    if (hi_pick[SRC_W]) begin
      valid_out = 1'b1;
      src_out   = hi_pick[SRC_W-1:0];
    end else begin
      valid_out = lo_pick[SRC_W];
      src_out   = lo_pick[SRC_W-1:0];
    end
  end
endmodule

//--- verif/iepf_src_model.sv
// Peripheral source model: cause and request flags held at their origin
`timescale 1ns/100ps
module iepf_src_model (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic [31:0] set_in,
  input  wire logic [31:0] clr_in,
  output logic      [31:0] flags_out
);
  // flags stay until software clears them here
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flags_out <= 32'h0;
    end else begin
      flags_out <= (flags_out & ~clr_in) | set_in;
    end
  end
endmodule

//--- verif/iepf_checker.sv
// Checker: bus, flag and request relations of the interrupt register set
`timescale 1ns/100ps
module iepf_checker
  import iepf_pkg::*;
#(
  parameter int unsigned CAUSES = CAUSE_W
) (
  input wire logic                core_clk_in,
  input wire logic                rst_in,
  input wire logic [ADDR_W-1:0]   addr_in,
  input wire logic [DATA_W-1:0]   wdata_in,
  input wire logic                wr_in,
  input wire logic                rd_in,
  input wire logic [DATA_W-1:0]   rdata_out,
  input wire logic                i2c_master_event_in,
  input wire logic [6*CAUSES-1:0] line_cause_in,
  input wire logic                irq_req_out,
  input wire logic [SRC_W-1:0]    irq_src_out,
  input wire logic                irq_high_out
);
  logic [5:0] any_cause;
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      any_cause[k] = |line_cause_in[k*CAUSES+:CAUSES];
    end
  end
  wire logic [7:1] lf       = {any_cause[5:3], 1'b0, any_cause[2:0]};
  wire logic       rd_flags = rd_in && addr_in == ADDR_EXT_FLAGS;
  wire logic       wr_flags = wr_in && addr_in == ADDR_EXT_FLAGS;
  wire logic       wr_ena   = wr_in && addr_in == ADDR_PRI_ENABLE;
  wire logic       gate_off = wr_ena && !wdata_in[GLOBAL_GATE_BIT];
  wire logic       mapped   = addr_in inside {8'h91, 8'ha8, 8'hb8, 8'he8, 8'hf8, 8'hc0, 8'hc1};
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);
  property p_rd_idle; !rd_in |=> rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_unmapped; rd_in && !mapped |=> rdata_out == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_prio_b7; rd_in && addr_in == ADDR_PRI_PRIORITY |=> !rdata_out[7]; endproperty
  a_prio_b7: assert property (p_prio_b7) else $error("priority bit 7 set");
  property p_i2c_sticky; i2c_master_event_in ##1 !wr_flags ##1 rd_flags |=> rdata_out[I2C_MASTER_BIT]; endproperty
  a_i2c_sticky: assert property (p_i2c_sticky) else $error("i2c pending lost");
  property p_line_live; rd_flags |=> rdata_out[7:1] == $past(lf); endproperty
  a_line_live: assert property (p_line_live) else $error("line flags wrong");
  property p_req_src; irq_req_out == (irq_src_out != NO_SOURCE); endproperty
  a_req_src: assert property (p_req_src) else $error("request and source disagree");
  property p_high_req; irq_high_out |-> irq_req_out; endproperty
  a_high_req: assert property (p_high_req) else $error("high level without request");
  property p_gate_off; gate_off ##1 (!wr_ena) [*3] |-> !irq_req_out; endproperty
  a_gate_off: assert property (p_gate_off) else $error("request with gate closed");
  c_gate: cover property (gate_off ##3 !irq_req_out);
  c_high: cover property (irq_high_out);
  c_i2c: cover property (i2c_master_event_in ##1 !wr_flags ##1 rd_flags);
endmodule
bind iepf_irq_regs iepf_checker #(.CAUSES(CAUSES)) u_chk (
  .core_clk_in         (core_clk_in),
  .rst_in              (rst_in),
  .addr_in             (addr_in),
  .wdata_in            (wdata_in),
  .wr_in               (wr_in),
  .rd_in               (rd_in),
  .rdata_out           (rdata_out),
  .i2c_master_event_in (i2c_master_event_in),
  .line_cause_in       (line_cause_in),
  .irq_req_out         (irq_req_out),
  .irq_src_out         (irq_src_out),
  .irq_high_out        (irq_high_out)
);

//--- verif/tb_top.sv
// Testbench: register, flag and request checks against a bench model
`timescale 1ns/100ps
module tb_top;
  import iepf_pkg::*;
  logic        clk, rst, wr, rd, ev, req, high, irq;
  logic [7:0]  addr, wdata, rdata;
  logic [3:0]  src;
  logic [31:0] setv, clrv, flags;
  int          errors, n_compared, cyc, seed, fl, s, d;
  int          r[4];
  logic [7:0]  ra[4] = '{8'ha8, 8'hb8, 8'he8, 8'hf8};
  logic [7:0]  m[4]  = '{8'h91, 8'hc0, 8'hc1, 8'h33};

  iepf_src_model peri (.core_clk_in(clk), .rst_in(rst), .set_in(setv), .clr_in(clrv), .flags_out(flags));
  iepf_irq_regs dut (.core_clk_in(clk), .rst_in(rst), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .pin_group0_req_in(flags[24]), .pin_group1_req_in(flags[25]), .timer0_flag_in(flags[26]),
    .timer1_flag_in(flags[27]), .timer2_flag_in(flags[28]), .uart0_req_in(flags[29]), .uart2_req_in(flags[30]),
    .watchdog_flag_in(flags[31]), .i2c_master_event_in(ev), .line_cause_in(flags[23:0]), .irq_req_out(req),
    .irq_src_out(src), .irq_high_out(high), .irq_out(irq));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Ceiling well above the roughly 1100 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrc(input logic [7:0] a, input int v);
    @(posedge clk);
    addr <= a;
    wdata <= v[7:0];
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [7:0] a, input int e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", e[7:0], rdata);
  endtask

  task automatic drv(input int v);
    @(posedge clk);
    setv <= v;
    clrv <= '1;
    @(posedge clk);
    setv <= '0;
    clrv <= '0;
  endtask

  task automatic evp();
    @(posedge clk);
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
  endtask

  function automatic logic [7:0] lf(input int v);
    logic [5:0] a;
    for (int k = 0; k < 6; k++) begin
      a[k] = |v[4*k+:4];
    end
    return {a[5:3], 1'b0, a[2:0], 1'b0};
  endfunction

  task automatic chk_req(input int v);
    logic [14:0] q, p;
    logic [7:0]  f, w;
    logic        h;
    f = lf(v);
    q = {f[7:5], v[31], f[3:1], fl[0], v[30], v[28], v[29], v[27], v[25], v[26], v[24]};
    q = q & {r[2][7:0], r[0][6:0]};
    p = {r[3][7:0], r[1][6:0]};
    w = 8'h0f;
    h = 1'b0;
    // Global gate first, then high level, then lowest index
    for (int l = 1; l >= 0; l--) begin
      for (int i = 0; i < 15; i++) begin
        if (r[0][7] && q[i] && p[i] == l && w == 8'h0f) begin
          w = 8'(i);
          h = 1'(l);
        end
      end
    end
    chk("irq_req", {7'h0, w != 8'h0f}, {7'h0, req});
    chk("irq_src", w, {4'h0, src});
    chk("irq_high", {7'h0, h}, {7'h0, high});
  endtask

  initial begin
    {wr, rd, ev, addr, wdata, setv, clrv} = '0;
    seed = 79370;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int j = 0; j < 4; j++) begin
      rdc(ra[j], 0);
      rdc(m[j], 0);
    end
    for (int k = 0; k < 40; k++) begin
      for (int j = 0; j < 4; j++) begin
        r[j] = $random(seed);
        wrc(ra[j], r[j]);
      end
      d = $random(seed);
      s = $random(seed) & $random(seed);
      drv(s);
      wrc(8'h91, d);
      fl = d & 1;
      if (d[1]) begin
        evp();
        fl = 1;
      end
      repeat (3) @(posedge clk);
      #1 chk_req(s);
      rdc(8'h91, lf(s) | fl);
      for (int j = 0; j < 4; j++) begin
        rdc(ra[j], r[j] & (j == 1 ? 8'h7f : 8'hff));
      end
    end
    // Two causes on one line, only one cleared at the origin
    r[0] = 32'h80;
    r[2] = 32'h02;
    wrc(8'ha8, r[0]);
    wrc(8'he8, r[2]);
    drv(32'h3);
    @(posedge clk);
    clrv <= 32'h1;
    @(posedge clk);
    clrv <= '0;
    repeat (3) @(posedge clk);
    #1 chk_req(2);
    rdc(8'h91, lf(2) | fl);
    wrc(8'hc0, 3);
    wrc(8'hc1, 2);
    evp();
    rdc(8'h91, 8'h03);
    chk("irq", 8'h01, {7'h0, irq});
    wrc(8'hc1, 0);
    @(posedge clk);
    #1 chk("irq", 8'h00, {7'h0, irq});
    wrc(8'hc1, 2);
    @(posedge clk);
    #1 chk("irq", 8'h01, {7'h0, irq});
    wrc(8'hc0, 2);
    @(posedge clk);
    #1 chk("irq", 8'h00, {7'h0, irq});
    // Closing and reopening the gate gives a fresh dispatch start
    wrc(8'ha8, 0);
    wrc(8'ha8, 8'h80);
    rdc(8'hc0, 1);
    wrc(8'hc1, 1);
    @(posedge clk);
    #1 chk("irq", 8'h01, {7'h0, irq});
    stop_test();
  end
endmodule
